//--- hw/eeprom_slave.sv
// Two-wire cached EEPROM slave with self-timed page programming
module eeprom_slave
    import eeprom_pkg::*;
(
    // Clocking
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic clk_en,
    // Chip select straps
    input wire logic [2:0] chip_select_pins,
    // Two-wire link
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Status
    output logic busy
);
    import eeprom_pkg::*;

    typedef enum logic [3:0] {
        S_IDLE, S_CTRL, S_AH, S_AL, S_WDATA, S_ACK, S_RBYTE, S_RACK,
        S_WAIT
    } phase_t;
    typedef enum logic [1:0] {P_IDLE, P_DRAIN, P_PROG} prog_t;

    typedef struct packed {
        logic [1:0] scl_s;
        logic [1:0] sda_s;
        logic scl_d;
        logic sda_d;
        phase_t ph;
        phase_t after_ack;
        logic [3:0] bitn;
        logic [7:0] sh;
        logic ack_drv;
        logic rd_drv;
        logic [15:0] ptr;
        logic [15:0] base;
        logic [2:0] line;
        logic [6:0] loaded;
        logic [LINES-1:0] line_used;
        prog_t pst;
        logic [2:0] pline;
        logic [3:0] didx;
        logic [31:0] tmr;
        logic sda_out;
        logic sda_oe;
        logic busy;
    } state_t;
    state_t s_r, s_nxt;

    logic [7:0] mem [MEM_BYTES];
    logic [7:0] cache [CACHE_BYTES];
    logic [CACHE_BYTES-1:0] cvalid_r;
    logic scl_rise, scl_fall, start_c, stop_c;
    logic f_in_valid, f_in_ready, f_out_valid, f_out_ready;
    logic [FIFO_WIDTH-1:0] f_in_data, f_out_data;
    logic [5:0] cidx;
    logic [5:0] drain_idx;
    logic [15:0] prog_base;
    logic [7:0] rd_byte;

    // Link edges from synchronised samples only
    assign scl_rise = s_r.scl_s[1] && !s_r.scl_d;
    assign scl_fall = !s_r.scl_s[1] && s_r.scl_d;
    assign start_c = s_r.scl_s[1] && s_r.scl_d && s_r.sda_d && !s_r.sda_s[1];
    assign stop_c = s_r.scl_s[1] && s_r.scl_d && !s_r.sda_d && s_r.sda_s[1];
    assign cidx = {s_r.line, s_r.ptr[2:0]};
    // Reads past 0FFF land in unused space and return erased data
    assign rd_byte = (s_r.ptr < 16'(MEM_BYTES)) ? mem[s_r.ptr[11:0]]
                                                : DATA_RESET;
    assign sda_out = s_r.sda_out;
    assign sda_oe = s_r.sda_oe;
    assign busy = s_r.busy;

    // Cache drain: every byte slot of the current line goes through the FIFO
    assign drain_idx = {s_r.pline, f_out_data[2:0]};
    // Line 0 always lands on the page that holds the start address
    assign prog_base = {s_r.base[15:3], 3'h0} +
                       {10'h000, s_r.pline, 3'h0};

    always_comb begin
        s_nxt = s_r;
        s_nxt.scl_s = {s_r.scl_s[0], scl_in};
        s_nxt.sda_s = {s_r.sda_s[0], sda_in};
        s_nxt.scl_d = s_r.scl_s[1];
        s_nxt.sda_d = s_r.sda_s[1];
        f_in_valid = 1'b0;
        f_in_data = '0;
        f_out_ready = 1'b0;
        if (start_c) begin
            // Repeated start keeps the pointer, drops pending write
            s_nxt.ph = s_r.busy ? S_IDLE : S_CTRL;
            s_nxt.bitn = '0;
            s_nxt.ack_drv = 1'b0;
            s_nxt.rd_drv = 1'b0;
            if (s_r.pst == P_IDLE && !s_r.busy) begin
                s_nxt.line_used = '0;
                s_nxt.loaded = '0;
            end
        end else if (stop_c) begin
            s_nxt.ph = S_IDLE;
            s_nxt.ack_drv = 1'b0;
            s_nxt.rd_drv = 1'b0;
            if (s_r.loaded != '0 && !s_r.busy) begin
                s_nxt.pst = P_DRAIN;
                s_nxt.busy = 1'b1;
                s_nxt.pline = '0;
                s_nxt.didx = '0;
            end
        end else if (scl_rise) begin
            case (s_r.ph)
                S_CTRL, S_AH, S_AL, S_WDATA: begin
                    s_nxt.sh = {s_r.sh[6:0], s_r.sda_s[1]};
                    s_nxt.bitn = s_r.bitn + 4'h1;
                end
                S_RACK: begin
                    // Master ack continues, no-ack waits for stop
                    s_nxt.ph = s_r.sda_s[1] ? S_WAIT : S_RBYTE;
                    // Every byte sent counts as accessed, ack or not
                    s_nxt.ptr = s_r.ptr + 16'h0001;
                end
                S_RBYTE: s_nxt.bitn = s_r.bitn + 4'h1;
                default: ;
            endcase
        end else if (scl_fall) begin
            case (s_r.ph)
                S_CTRL, S_AH, S_AL, S_WDATA: begin
                    if (s_r.bitn == 4'h8) begin
                        s_nxt.bitn = '0;
                        s_nxt.ack_drv = 1'b1;
                        s_nxt.ph = S_ACK;
                        case (s_r.ph)
                            S_CTRL: begin
                                if (s_r.sh[7:4] != CTRL_CODE ||
                                    s_r.sh[3:1] != chip_select_pins) begin
                                    s_nxt.ack_drv = 1'b0;
                                    s_nxt.ph = S_WAIT;
                                end else begin
                                    s_nxt.after_ack = s_r.sh[0] ? S_RBYTE
                                                                : S_AH;
                                end
                            end
                            S_AH: begin
                                s_nxt.ptr[15:8] = s_r.sh;
                                s_nxt.after_ack = S_AL;
                            end
                            S_AL: begin
                                s_nxt.ptr[7:0] = s_r.sh;
                                s_nxt.base = {s_nxt.ptr[15:8], s_r.sh};
                                s_nxt.line = '0;
                                s_nxt.after_ack = S_WDATA;
                            end
                            default: begin
                                // Byte lands in the cache, six low bits roll
                                s_nxt.loaded = s_r.loaded + 7'h01;
                                s_nxt.line_used[s_r.line] = 1'b1;
                                s_nxt.ptr[5:0] = s_r.ptr[5:0] + 6'h01;
                                if (s_r.ptr[2:0] == 3'h7) begin
                                    s_nxt.line = s_r.line + 3'h1;
                                end
                                s_nxt.after_ack = S_WDATA;
                            end
                        endcase
                    end
                end
                S_ACK: begin
                    s_nxt.ack_drv = 1'b0;
                    s_nxt.ph = s_r.after_ack;
                    if (s_r.after_ack == S_RBYTE) begin
                        s_nxt.sh = rd_byte;
                        s_nxt.rd_drv = 1'b1;
                        s_nxt.bitn = '0;
                    end
                end
                S_RBYTE: begin
                    if (s_r.bitn == 4'h8) begin
                        s_nxt.rd_drv = 1'b0;
                        s_nxt.ph = S_RACK;
                        s_nxt.bitn = '0;
                    end else begin
                        s_nxt.sh = {s_r.sh[6:0], 1'b1};
                    end
                end
                S_RACK: ;
                default: ;
            endcase
            if (s_r.ph == S_RACK) begin
                s_nxt.ptr = s_r.ptr;
            end
        end
        // Next read byte reloads after a master ack
        if (scl_fall && s_r.ph == S_RBYTE && s_r.bitn == 4'h0) begin
            s_nxt.sh = rd_byte;
            s_nxt.rd_drv = 1'b1;
        end
        // Programming sequencer, timed on sys_clk only
        case (s_r.pst)
            P_DRAIN: begin
                // Drain time is part of the page time, so a page costs 5 ms
                s_nxt.tmr = s_r.tmr + 32'h1;
                f_out_ready = 1'b1;
                if (!s_r.line_used[s_r.pline]) begin
                    s_nxt.pline = s_r.pline + 3'h1;
                end else if (!s_r.didx[3]) begin
                    f_in_valid = 1'b1;
                    f_in_data = {1'b1, 5'h00, s_r.didx[2:0]};
                    if (f_in_ready) begin
                        s_nxt.didx = s_r.didx + 4'h1;
                    end
                end else if (!f_out_valid) begin
                    s_nxt.pst = P_PROG;
                end
            end
            P_PROG: begin
                // Full page time even for a partial line
                s_nxt.tmr = s_r.tmr + 32'h1;
                if (s_r.tmr == 32'(PAGE_WRITE_CYC - 1)) begin
                    s_nxt.tmr = '0;
                    s_nxt.didx = '0;
                    s_nxt.line_used[s_r.pline] = 1'b0;
                    if (s_nxt.line_used == '0) begin
                        s_nxt.pst = P_IDLE;
                        s_nxt.busy = 1'b0;
                        s_nxt.loaded = '0;
                    end else begin
                        s_nxt.pline = s_r.pline + 3'h1;
                        s_nxt.pst = P_DRAIN;
                    end
                end
            end
            default: ;
        endcase
        s_nxt.sda_oe = (s_nxt.ack_drv && !s_r.busy) ||
                       (s_nxt.rd_drv && !s_nxt.sh[7]);
        s_nxt.sda_out = 1'b0;
    end

    byte_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
        .sys_clk(sys_clk),
        .srst(srst),
        .clk_en(clk_en),
        .in_valid(f_in_valid),
        .in_ready(f_in_ready),
        .in_data(f_in_data),
        .out_valid(f_out_valid),
        .out_ready(f_out_ready),
        .out_data(f_out_data)
    );

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            s_r <= '{scl_s: 2'h3, sda_s: 2'h3, scl_d: 1'b1, sda_d: 1'b1,
                     ph: S_IDLE, after_ack: S_IDLE, pst: P_IDLE,
                     ptr: ADDR_RESET, base: ADDR_RESET, default: '0};
            cvalid_r <= '0;
        end else if (clk_en) begin
            s_r <= s_nxt;
            // Bytes of a write cut short by a new START must not program
            if (start_c && !s_r.busy) begin
                cvalid_r <= '0;
            end
            if (scl_fall && s_r.ph == S_WDATA && s_r.bitn == 4'h8) begin
                cache[cidx] <= s_r.sh;
                cvalid_r[cidx] <= 1'b1;
            end
            if (f_out_valid && f_out_ready) begin
                // Only loaded bytes reach the array
                if (cvalid_r[drain_idx]) begin
                    mem[12'(prog_base + 16'(f_out_data[2:0]))] <=
                        cache[drain_idx];
                    cvalid_r[drain_idx] <= 1'b0;
                end
            end
        end
    end

    no_ack_busy_a: assert property (@(posedge sys_clk) disable iff (srst)
        s_r.busy |-> !s_r.sda_oe)
        else $error("acknowledge driven while programming");
    idle_release_a: assert property (@(posedge sys_clk) disable iff (srst)
        s_r.ph == S_IDLE && $past(s_r.ph) == S_IDLE |-> !s_r.sda_oe)
        else $error("data line held outside transfer");
    line_wrap_a: assert property (@(posedge sys_clk) disable iff (srst)
        scl_fall && s_r.ph == S_WDATA && s_r.bitn == 4'h8 |=>
        s_r.ptr[15:6] == $past(s_r.ptr[15:6]))
        else $error("high pointer bits changed by data byte");
    busy_start_a: assert property (@(posedge sys_clk) disable iff (srst)
        stop_c && clk_en && s_r.loaded != '0 && !s_r.busy |=> s_r.busy)
        else $error("stop did not start programming");
    out_zero_a: assert property (@(posedge sys_clk) disable iff (srst)
        !s_r.sda_out)
        else $error("open drain driven high");
    rd_ptr_a: assert property (@(posedge sys_clk) disable iff (srst)
        clk_en && scl_rise && s_r.ph == S_RACK |=>
        s_r.ptr == $past(s_r.ptr) + 16'h0001)
        else $error("read pointer not advanced");
    prog_time_a: assert property (@(posedge sys_clk) disable iff (srst)
        s_r.pst == P_PROG |-> s_r.busy)
        else $error("idle during page programming");
    ctrl_nack_a: assert property (@(posedge sys_clk) disable iff (srst)
        s_r.ph == S_ACK && s_r.after_ack == S_AH |-> s_r.sh[7:4] == CTRL_CODE
        || $past(s_r.ph) != S_CTRL)
        else $error("acknowledged a foreign control code");
    write_cv: cover property (@(posedge sys_clk) s_r.pst == P_PROG);
    read_cv: cover property (@(posedge sys_clk) s_r.ph == S_RBYTE);
    poll_cv: cover property (@(posedge sys_clk) s_r.busy && start_c);
endmodule

//--- hw/eeprom_pkg.sv
// Shared constants for the cached two-wire EEPROM slave
package eeprom_pkg;
    localparam logic [3:0] CTRL_CODE = 4'ha;
    localparam int MEM_BYTES = 4096;
    localparam int CACHE_BYTES = 64;
    localparam int LINE_BYTES = 8;
    localparam int LINES = 8;
    localparam int FIFO_WIDTH = 9;
    localparam int FIFO_DEPTH = 16;
    localparam int CLK_HZ = 20000000;
    localparam int PAGE_WRITE_MS = 5;
    localparam int PAGE_WRITE_CYC = PAGE_WRITE_MS * (CLK_HZ / 1000);
    localparam logic [15:0] ADDR_RESET = 16'h0000;
    localparam logic [7:0] DATA_RESET = 8'hff;
endpackage

//--- hw/byte_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides
module byte_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    // Clocking
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic clk_en,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
    } fifo_t;
    fifo_t s_r, s_nxt;
    logic push, pop;

    assign in_ready = s_r.cnt != (AW+1)'(DEPTH);
    assign out_valid = s_r.cnt != '0;
    assign out_data = s_r.mem[s_r.rd];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        s_nxt = s_r;
        if (push) begin
            s_nxt.mem[s_r.wr] = in_data;
            s_nxt.wr = s_r.wr + 1'b1;
        end
        if (pop) begin
            s_nxt.rd = s_r.rd + 1'b1;
        end
        s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            s_r <= '0;
        end else if (clk_en) begin
            s_r <= s_nxt;
        end
    end

    fifo_bound_a: assert property (@(posedge sys_clk) disable iff (srst)
        s_r.cnt <= (AW+1)'(DEPTH))
        else $error("fifo count beyond depth");
endmodule

//--- verification/link_master.sv
// Two-wire bus master model: drives the clock, pulls data low
module link_master (
    // Clocking
    input wire logic clk,
    // Bus
    input wire logic sda_line,
    output logic scl,
    output logic sda_low
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Data moves only while the clock is low; sample late in high phase
    task automatic slot(input logic pull, output logic seen);
        scl <= 1'b0;
        tick(1);
        sda_low <= pull;
        tick(3);
        scl <= 1'b1;
        tick(3);
        seen = sda_line;
        tick(1);
    endtask
    task automatic start_c();
        scl <= 1'b0;
        tick(1);
        sda_low <= 1'b0;
        tick(3);
        scl <= 1'b1;
        tick(2);
        sda_low <= 1'b1;
        tick(2);
    endtask
    task automatic stop_c();
        scl <= 1'b0;
        tick(1);
        sda_low <= 1'b1;
        tick(3);
        scl <= 1'b1;
        tick(2);
        sda_low <= 1'b0;
        tick(6);
    endtask
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            slot(~b[i], s);
        slot(1'b0, s);
        ack = ~s;
    endtask
    task automatic get_byte(output logic [7:0] b, input logic ack_it);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            slot(1'b0, s);
            b[i] = s;
        end
        slot(ack_it, s);
    endtask
endmodule

//--- verification/eeprom_slave_tb_top.sv
// Bench for the cached EEPROM slave and its byte FIFO
module eeprom_slave_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import eeprom_pkg::*;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic clk_en = 1'b1;
    logic [2:0] sel = 3'h0;
    logic scl, mst_low, sda_line, sda_out, sda_oe, busy;
    int err_total = 0;
    int n_tests = 0;
    int busy_cyc = 0;
    int ptr_m;
    logic [7:0] mem_m [int];
    logic ack;
    logic [7:0] d;
    always #25 sys_clk = ~sys_clk;
    // Open drain with pull-up
    assign sda_line = (mst_low || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;
    always @(posedge sys_clk)
        if (busy === 1'b1)
            busy_cyc <= busy_cyc + 1;
    eeprom_slave eeprom_slave_i (
        .sys_clk(sys_clk), .srst(srst), .clk_en(clk_en),
        .chip_select_pins(sel), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .busy(busy)
    );
    link_master link_master_i (
        .clk(sys_clk), .sda_line(sda_line), .scl(scl), .sda_low(mst_low)
    );
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic tally(input logic bad, input string msg);
        n_tests++;
        if (bad) begin
            err_total++;
            $display("mismatch %s", msg);
        end
    endtask
    task automatic chk_bit(input string w, input logic e, input logic s);
        tally(s !== e, $sformatf("%s expected %b seen %b", w, e, s));
    endtask
    task automatic chk_data(input string w, input logic [8:0] e,
                            input logic [8:0] s);
        tally(s !== e, $sformatf("%s expected %h seen %h", w, e, s));
    endtask
    task automatic chk_cnt(input string w, input int e, input int s);
        tally(s != e, $sformatf("%s expected %0d seen %0d", w, e, s));
    endtask
    function automatic logic [7:0] ctrl(input logic [2:0] s, input logic rd);
        return {CTRL_CODE, s, rd};
    endfunction
    // Space above the array reads as erased
    function automatic logic [7:0] exp_at(input int a);
        return (a >= MEM_BYTES) ? 8'hff : mem_m[a];
    endfunction
    task automatic addr_bytes(input logic [15:0] a);
        logic k;
        link_master_i.put_byte(a[15:8] & 8'h0f, k);
        chk_bit("addr hi ack", 1'b1, k);
        link_master_i.put_byte(a[7:0], k);
        chk_bit("addr lo ack", 1'b1, k);
        ptr_m = a;
    endtask
    task automatic set_addr(input logic [15:0] a);
        logic k;
        link_master_i.start_c();
        link_master_i.put_byte(ctrl(sel, 1'b0), k);
        chk_bit("ctrl write ack", 1'b1, k);
        addr_bytes(a);
    endtask
    task automatic read_run(input int n);
        logic k;
        logic [7:0] b;
        link_master_i.start_c();
        link_master_i.put_byte(ctrl(sel, 1'b1), k);
        chk_bit("ctrl read ack", 1'b1, k);
        for (int i = 0; i < n; i++) begin
            link_master_i.get_byte(b, i < n - 1);
            chk_data("read data", {1'b0, exp_at(ptr_m)}, {1'b0, b});
            ptr_m++;
        end
        link_master_i.stop_c();
        chk_bit("data released", 1'b0, sda_oe);
    endtask
    initial begin
        void'($urandom(32'hace1cedb));
        repeat (12) @(posedge sys_clk);
        srst <= 1'b0;
        sel <= 3'($urandom());
        repeat (10) @(posedge sys_clk);
        // Each wrong select bit in turn, then a foreign code
        for (int k = 0; k < 4; k++) begin
            d = ctrl(sel ^ (3'h1 << k), 1'b0);
            if (k == 3)
                d[7:4] = CTRL_CODE ^ 4'(1 + $urandom_range(14));
            link_master_i.start_c();
            link_master_i.put_byte(d, ack);
            chk_bit("foreign ctrl ack", 1'b0, ack);
            link_master_i.stop_c();
        end
        // One full line only: each page costs a long self-timed cycle
        set_addr(16'h0ff8);
        for (int i = 0; i < LINE_BYTES; i++) begin
            d = 8'($urandom());
            link_master_i.put_byte(d, ack);
            chk_bit("data ack", 1'b1, ack);
            mem_m[16'h0ff8 + i] = d;
        end
        link_master_i.stop_c();
        chk_bit("busy after stop", 1'b1, busy);
        link_master_i.start_c();
        link_master_i.put_byte(ctrl(sel, 1'b1), ack);
        chk_bit("ack while writing", 1'b0, ack);
        link_master_i.stop_c();
        ack = 1'b0;
        for (int p = 0; p < 2000 && ack !== 1'b1; p++) begin
            link_master_i.start_c();
            link_master_i.put_byte(ctrl(sel, 1'b0), ack);
            if (ack !== 1'b1)
                link_master_i.stop_c();
        end
        chk_bit("poll answered", 1'b1, ack);
        if (ack !== 1'b1)
            report_and_stop();
        chk_cnt("busy cycles", PAGE_WRITE_CYC, busy_cyc);
        chk_bit("idle after poll", 1'b0, busy);
        addr_bytes(16'h0ff8);
        read_run(1);
        chk_bit("no write after abort", 1'b0, busy);
        read_run(1);
        set_addr(16'h0ffa);
        read_run(8);
        // Reads and aborted writes must not start programming
        chk_cnt("busy cycles kept", PAGE_WRITE_CYC, busy_cyc);
        // Reset in mid-run: link released, array content kept
        srst <= 1'b1;
        repeat (12) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        chk_bit("busy after reset", 1'b0, busy);
        chk_bit("released after reset", 1'b0, sda_oe);
        repeat (3) @(posedge sys_clk);
        // Whole line back through the drain path
        set_addr(16'h0ff8);
        read_run(8);
        report_and_stop();
    end
endmodule
